// >>> verilog/timing_loop_master_config.sv
// master configuration registers of the timing loops and composite receivers
`timescale 1ns/1ps
`include "timing_loop_defines.svh"

// Operation
// [R1] auto mode: frame sync used only if enabled and main loop locked to source
// [R2] phase alarms stay until software clears, or auto-clear after 128 s timeout
// [R3] local oscillator edge select: 0 rising, 1 falling
// [R4] manual holdover takes holdover frequency from register value, overriding all else
// [R5] frame sync enable makes main loop look at frame sync pin, else ignored
// [R6] rate family select: input code 0001 means 2048 khz or 1544 rate
// [R7] rate family default is caught from its strap pin at reset
// [R8] primary/secondary bit is read-only, shows its pin level
// [R9] secondary: input eleven priority 1, acquisition bandwidth, revertive, no build-out
// [R10] revertive: higher-priority valid input replaces selected reference immediately
// [R11] secondary mode: revertive bit stored on write, reads back as one
// [R12] aux loop follows main loop output when set, else independent
// [R13] aux loop feedback: 0 analog, 1 digital; resets to 1
// [R14] outputs eight and nine driven by aux loop (0) or main loop (1)
// [R15] aux force codes 1..14 force that input; 0 and 15 automatic
// [R16] forced aux input declared invalid: aux loop must not switch away
// [R17] composite edge: 0 pulse after violation, 1 violation itself
// [R18] bit errors count as irregularity; bucket bumps once per 128 ms interval
// [R19] invalidate composite input on bad violation pattern two frames running
// [R20] invalidate composite input on two consecutive zero bits
// [R21] input two format: 0 composite on alternate pin, 1 logic on normal pin
// [R22] input one format: 0 composite on alternate pin, 1 logic on normal pin
// [R23] unused aux control bit five reads zero and ignores writes
module timing_loop_master_config
  import timing_loop_pkg::*;
#(
  parameter logic [31:0] ALARM_TIMEOUT_CYC = 32'(`ALARM_TIMEOUT_CYC),
  parameter logic [31:0] BUCKET_INT_CYC    = 32'(`BUCKET_INT_CYC),
  parameter int          NUM_REFS          = NUM_INPUTS
) (
  input  wire logic            mclk_i,
  input  wire logic            nrst_i,
  input  wire logic [7:0]      reg_addr_i,
  input  wire logic            reg_wr_i,
  input  wire logic            reg_rd_i,
  input  wire logic [7:0]      reg_wdata_i,
  output reg_byte_type         reg_rdata_o,
  input  wire logic            primary_pin_i,
  input  wire logic            rate_strap_pin_i,
  input  wire logic            frame_sync_pin_i,
  input  wire logic            local_osc_in_i,
  input  wire logic            main_locked_i,
  input  wire ref_code_type    main_lock_src_i,
  input  wire ref_code_type    fsync_source_i,
  input  wire logic [13:0]     phase_alarm_set_i,
  input  wire logic [13:0]     phase_alarm_clr_i,
  input  wire logic [13:0]     ref_valid_i,
  input  wire logic [1:0]      cc_bit_stb_i,
  input  wire logic [1:0]      cc_mark_i,
  input  wire logic [1:0]      cc_bpv_i,
  output logic                 fsync_used_o,
  output logic                 fsync_pulse_o,
  output logic [13:0]          phase_alarm_o,
  output logic                 local_osc_edge_o,
  output logic                 holdover_manual_o,
  output logic                 rate_1544_o,
  output logic                 input_eleven_prio1_o,
  output logic                 acq_bw_forced_o,
  output logic                 revertive_eff_o,
  output logic                 pbo_disable_o,
  output logic                 aux_follows_main_o,
  output logic                 aux_digital_fb_o,
  output logic                 out8_9_from_main_o,
  output ref_code_type         aux_forced_ref_o,
  output logic                 aux_switch_inhibit_o,
  output logic [1:0]           cc_timing_pulse_o,
  output logic [1:0]           cc_bucket_inc_o,
  output logic [1:0]           cc_invalid_o,
  output logic                 in1_cmos_o,
  output logic                 in2_cmos_o
);
  initial begin
    if (NUM_REFS != 14) $error("NUM_REFS must be 14");
    if (ALARM_TIMEOUT_CYC < 32'd2) $error("alarm timeout too short");
  end

  // =====================================================================
  // pin synchronisers
  localparam int NPIN = 10;
  logic [NPIN-1:0] pin_meta_ff;
  logic [NPIN-1:0] pin_sync_ff;
  logic [NPIN-1:0] pin_raw;
  logic            primary_s;
  logic            strap_s;
  logic            fsync_s;
  logic            osc_s;
  logic [1:0]      stb_s;
  logic [1:0]      mark_s;
  logic [1:0]      bpv_s;

  assign pin_raw = {cc_bpv_i, cc_mark_i, cc_bit_stb_i, local_osc_in_i,
                    frame_sync_pin_i, rate_strap_pin_i, primary_pin_i};
  assign primary_s = pin_sync_ff[0];
  assign strap_s   = pin_sync_ff[1];
  assign fsync_s   = pin_sync_ff[2];
  assign osc_s     = pin_sync_ff[3];
  assign stb_s     = pin_sync_ff[5:4];
  assign mark_s    = pin_sync_ff[7:6];
  assign bpv_s     = pin_sync_ff[9:8];

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= pin_raw;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // =====================================================================
  // register storage
  reg_byte_type main_cfg_ff;
  reg_byte_type aux_ctrl_ff;
  reg_byte_type cc_ctrl_ff;
  logic [1:0]   strap_wait_ff;
  logic         strap_done_ff;
  logic         wr_main;
  logic         wr_aux;
  logic         wr_cc;
  logic         secondary;

  assign wr_main   = reg_wr_i && (reg_addr_i == `MAIN_CFG_ADDR);
  assign wr_aux    = reg_wr_i && (reg_addr_i == `AUX_CTRL_ADDR);
  assign wr_cc     = reg_wr_i && (reg_addr_i == `CC_CTRL_ADDR);
  assign secondary = !primary_s; // [R9]

  // strap is caught once the synchroniser has settled after release
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_wait_ff <= 2'h0;
      strap_done_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_wait_ff <= strap_wait_ff + 2'h1;
      strap_done_ff <= (strap_wait_ff == 2'h2);
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      main_cfg_ff <= `MC_RESET;
    end else if (wr_main) begin
      main_cfg_ff <= reg_wdata_i & ~(8'h1 << `MC_PRIMARY_BIT); // [R11]
    end else if (!strap_done_ff && (strap_wait_ff == 2'h2)) begin
      main_cfg_ff[`MC_RATE_BIT] <= strap_s; // [R7]
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aux_ctrl_ff <= `AX_RESET; // [R13]
    end else if (wr_aux) begin
      aux_ctrl_ff <= reg_wdata_i & ~(8'h1 << `AX_UNUSED_BIT); // [R23]
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cc_ctrl_ff <= `CC_RESET;
    end else if (wr_cc) begin
      cc_ctrl_ff <= reg_wdata_i;
    end
  end

  // =====================================================================
  // read port
  reg_byte_type main_rd;

  always_comb begin
    main_rd = main_cfg_ff;
    main_rd[`MC_PRIMARY_BIT] = primary_s; // [R8]
    main_rd[`MC_REVERTIVE_EN_BIT]  = main_cfg_ff[`MC_REVERTIVE_EN_BIT] || secondary; // [R11]
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `MAIN_CFG_ADDR: reg_rdata_o <= main_rd;
        `AUX_CTRL_ADDR: reg_rdata_o <= aux_ctrl_ff;
        `CC_CTRL_ADDR:  reg_rdata_o <= cc_ctrl_ff;
        default:        reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // =====================================================================
  // frame sync gating
  logic fsync_prev_ff;
  logic fsync_use;

  assign fsync_use = main_cfg_ff[`MC_EXT_FSYNC_EN_BIT] &&
                     (!main_cfg_ff[`MC_EXT_FSYNC_AUTO_EN_BIT] ||
                      (main_locked_i && (main_lock_src_i == fsync_source_i))); // [R1]

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fsync_prev_ff <= 1'b0;
      fsync_used_o  <= 1'b0;
      fsync_pulse_o <= 1'b0;
    end else begin
      fsync_prev_ff <= fsync_s;
      fsync_used_o  <= fsync_use; // [R1]
      fsync_pulse_o <= fsync_use && fsync_s && !fsync_prev_ff; // [R5]
    end
  end

  // =====================================================================
  // local oscillator edge
  logic osc_prev_ff;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_prev_ff      <= 1'b0;
      local_osc_edge_o <= 1'b0;
    end else begin
      osc_prev_ff      <= osc_s;
      local_osc_edge_o <= main_cfg_ff[`MC_OSCEDGE_BIT] ?
                          (osc_prev_ff && !osc_s) : (!osc_prev_ff && osc_s); // [R3]
    end
  end

  // =====================================================================
  // phase alarms with optional timeout
  logic timeout_en;

  assign timeout_en = main_cfg_ff[`MC_TIMEOUT_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < 14; gi++) begin : g_alarm
      logic [31:0] age_ff;
      logic        expired;

      assign expired = timeout_en && (age_ff == ALARM_TIMEOUT_CYC - 32'd1);

      always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          age_ff            <= 32'h0;
          phase_alarm_o[gi] <= 1'b0;
        end else if (phase_alarm_set_i[gi]) begin
          age_ff            <= 32'h0;
          phase_alarm_o[gi] <= 1'b1; // [R2]
        end else if (phase_alarm_clr_i[gi] || expired) begin
          age_ff            <= 32'h0;
          phase_alarm_o[gi] <= 1'b0; // [R2]
        end else if (phase_alarm_o[gi] && timeout_en) begin
          age_ff            <= age_ff + 32'h1;
        end else begin
          age_ff            <= 32'h0;
        end
      end
    end
  endgenerate

  // =====================================================================
  // main loop controls
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      holdover_manual_o    <= 1'b0;
      rate_1544_o          <= 1'b0;
      input_eleven_prio1_o <= 1'b0;
      acq_bw_forced_o      <= 1'b0;
      revertive_eff_o      <= 1'b0;
      pbo_disable_o        <= 1'b0;
    end else begin
      holdover_manual_o    <= main_cfg_ff[`MC_MANHOLD_BIT]; // [R4]
      rate_1544_o          <= main_cfg_ff[`MC_RATE_BIT]; // [R6]
      input_eleven_prio1_o <= secondary; // [R9]
      acq_bw_forced_o      <= secondary; // [R9]
      pbo_disable_o        <= secondary; // [R9]
      revertive_eff_o      <= main_cfg_ff[`MC_REVERTIVE_EN_BIT] || secondary; // [R10]
    end
  end

  // =====================================================================
  // aux loop controls
  ref_code_type force_code;
  logic         force_active;
  logic [3:0]   force_idx;

  assign force_code   = aux_ctrl_ff[`AX_FORCE_MSB:`AX_FORCE_LSB];
  assign force_active = (force_code != `AX_FORCE_AUTO_LO) &&
                        (force_code != `AX_FORCE_AUTO_HI); // [R15]
  assign force_idx    = force_code - 4'h1;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aux_follows_main_o   <= 1'b0;
      aux_digital_fb_o     <= 1'b1;
      out8_9_from_main_o   <= 1'b0;
      aux_forced_ref_o     <= 4'h0;
      aux_switch_inhibit_o <= 1'b0;
    end else begin
      aux_follows_main_o   <= aux_ctrl_ff[`AX_FOLLOW_BIT]; // [R12]
      aux_digital_fb_o     <= aux_ctrl_ff[`AX_DIGFB_BIT]; // [R13]
      out8_9_from_main_o   <= aux_ctrl_ff[`AX_OUT89_BIT]; // [R14]
      aux_forced_ref_o     <= force_active ? force_code : 4'h0; // [R15]
      aux_switch_inhibit_o <= force_active && !ref_valid_i[force_idx]; // [R16]
    end
  end

  // =====================================================================
  // composite receivers
  logic [1:0] cmos_fmt;

  assign cmos_fmt = {cc_ctrl_ff[`CC_IN2FMT_BIT], cc_ctrl_ff[`CC_IN1FMT_BIT]};

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in1_cmos_o <= 1'b0;
      in2_cmos_o <= 1'b0;
    end else begin
      in1_cmos_o <= cmos_fmt[0]; // [R22]
      in2_cmos_o <= cmos_fmt[1]; // [R21]
    end
  end

  generate
    for (gi = 0; gi < 2; gi++) begin : g_cc
      composite_rx_monitor #(
        .INTERVAL_CYC (BUCKET_INT_CYC)
      ) u_mon (
        .mclk_i           (mclk_i),
        .nrst_i           (nrst_i),
        .bit_stb_i        (stb_s[gi]),
        .mark_i           (mark_s[gi]),
        .bpv_i            (bpv_s[gi]),
        .composite_mode_i (!cmos_fmt[gi]),
        .edge_sel_i       (cc_ctrl_ff[`CC_EDGE_BIT]),
        .bit_error_count_en_en_i      (cc_ctrl_ff[`CC_BIT_ERROR_COUNT_EN_BIT]),
        .ami_inv_en_i     (cc_ctrl_ff[`CC_AMI_BIT]),
        .los_inv_en_i     (cc_ctrl_ff[`CC_LOS_BIT]),
        .timing_pulse_o   (cc_timing_pulse_o[gi]),
        .bucket_inc_o     (cc_bucket_inc_o[gi]),
        .invalid_o        (cc_invalid_o[gi])
      );
    end
  endgenerate
endmodule // timing_loop_master_config

// >>> verilog/timing_loop_defines.svh
// offsets, field positions, reset values and timing counts of the master configuration bank
`ifndef TIMING_LOOP_DEFINES_SVH
`define TIMING_LOOP_DEFINES_SVH

// =====================================================================
// register offsets
`define MAIN_CFG_ADDR      8'h34
`define AUX_CTRL_ADDR      8'h35
`define CC_CTRL_ADDR       8'h36

// =====================================================================
// main_loop_master_config fields
`define MC_EXT_FSYNC_AUTO_EN_BIT      7
`define MC_TIMEOUT_BIT     6
`define MC_OSCEDGE_BIT     5
`define MC_MANHOLD_BIT     4
`define MC_EXT_FSYNC_EN_BIT       3
`define MC_RATE_BIT        2
`define MC_PRIMARY_BIT     1
`define MC_REVERTIVE_EN_BIT      0
`define MC_RESET           8'hc0

// =====================================================================
// aux_loop_control fields
`define AX_FOLLOW_BIT      7
`define AX_DIGFB_BIT       6
`define AX_UNUSED_BIT      5
`define AX_OUT89_BIT       4
`define AX_FORCE_MSB       3
`define AX_FORCE_LSB       0
`define AX_RESET           8'h40
`define AX_FORCE_AUTO_LO   4'h0
`define AX_FORCE_AUTO_HI   4'hf

// =====================================================================
// composite_receiver_control fields
`define CC_EDGE_BIT        7
`define CC_BIT_ERROR_COUNT_EN_BIT      6
`define CC_AMI_BIT         5
`define CC_LOS_BIT         4
`define CC_IN2FMT_BIT      3
`define CC_IN1FMT_BIT      2
`define CC_RESET           8'h02

// =====================================================================
// timing
`define CLK_HZ             64'd25000000
`define ALARM_TIMEOUT_S    64'd128
`define BUCKET_INTERVAL_MS 64'd128
`define ALARM_TIMEOUT_CYC  (`ALARM_TIMEOUT_S * `CLK_HZ)
`define BUCKET_INT_CYC     ((`BUCKET_INTERVAL_MS * `CLK_HZ) / 64'd1000)
`define CC_BITS_PER_FRAME  3'h7

`endif

// >>> verilog/timing_loop_pkg.sv
// types shared by the master configuration bank
package timing_loop_pkg;
  typedef logic [7:0] reg_byte_type;
  typedef logic [3:0] ref_code_type;
  localparam int NUM_INPUTS = 14;
endpackage

// >>> verilog/composite_rx_monitor.sv
// bipolar composite clock pattern monitor for one composite input
`timescale 1ns/1ps
`include "timing_loop_defines.svh"

module composite_rx_monitor #(
  parameter logic [31:0] INTERVAL_CYC = 32'(`BUCKET_INT_CYC)
) (
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  input  wire logic bit_stb_i,
  input  wire logic mark_i,
  input  wire logic bpv_i,
  input  wire logic composite_mode_i,
  input  wire logic edge_sel_i,
  input  wire logic bit_error_count_en_en_i,
  input  wire logic ami_inv_en_i,
  input  wire logic los_inv_en_i,
  output logic      timing_pulse_o,
  output logic      bucket_inc_o,
  output logic      invalid_o
);
  initial begin
    if (INTERVAL_CYC < 32'd2) $error("interval too short");
  end

  logic [2:0]  bit_cnt_ff;
  logic [3:0]  bpv_cnt_ff;
  logic        err_prev_ff;
  logic        zero_prev_ff;
  logic        bpv_prev_ff;
  logic        irr_ff;
  logic [31:0] int_cnt_ff;
  logic        frame_end;
  logic        frame_err;
  logic        int_end;

  assign frame_end = bit_stb_i && (bit_cnt_ff == `CC_BITS_PER_FRAME);
  assign frame_err = frame_end && ((bpv_cnt_ff + 4'(bpv_i)) != 4'h1);
  assign int_end   = (int_cnt_ff == INTERVAL_CYC - 32'd1);

  // =====================================================================
  // bit and violation counting over 8-bit frames
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_cnt_ff   <= 3'h0;
      bpv_cnt_ff   <= 4'h0;
      err_prev_ff  <= 1'b0;
      zero_prev_ff <= 1'b0;
      bpv_prev_ff  <= 1'b0;
    end else if (bit_stb_i) begin
      bit_cnt_ff   <= bit_cnt_ff + 3'h1;
      bpv_cnt_ff   <= frame_end ? 4'h0 : bpv_cnt_ff + 4'(bpv_i);
      zero_prev_ff <= !mark_i;
      bpv_prev_ff  <= bpv_i;
      if (frame_end) begin
        err_prev_ff <= frame_err;
      end
    end
  end

  // =====================================================================
  // 8 khz timing edge
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timing_pulse_o <= 1'b0;
    end else begin
      timing_pulse_o <= composite_mode_i && bit_stb_i && mark_i &&
                        (edge_sel_i ? bpv_i : bpv_prev_ff); // [R17]
    end
  end

  // =====================================================================
  // irregularity flag and leaky bucket interval
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_cnt_ff   <= 32'h0;
      irr_ff       <= 1'b0;
      bucket_inc_o <= 1'b0;
    end else begin
      int_cnt_ff   <= int_end ? 32'h0 : int_cnt_ff + 32'h1;
      bucket_inc_o <= int_end && (irr_ff || (frame_err && bit_error_count_en_en_i)); // [R18]
      if (int_end) begin
        irr_ff <= 1'b0;
      end else if (frame_err && bit_error_count_en_en_i && composite_mode_i) begin
        irr_ff <= 1'b1; // [R18]
      end
    end
  end

  // =====================================================================
  // invalidation
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      invalid_o <= 1'b0;
    end else if (!composite_mode_i) begin
      invalid_o <= 1'b0;
    end else if (ami_inv_en_i && frame_err && err_prev_ff) begin
      invalid_o <= 1'b1; // [R19]
    end else if (los_inv_en_i && bit_stb_i && !mark_i && zero_prev_ff) begin
      invalid_o <= 1'b1; // [R20]
    end else if (frame_end && !frame_err) begin
      invalid_o <= 1'b0;
    end
  end
endmodule // composite_rx_monitor

// >>> sim/tlmc_properties.sv
// concurrent checks on the master configuration bank ports
`timescale 1ns/1ps
module tlmc_properties
  import timing_loop_pkg::*;
(
  input wire logic         mclk_i,
  input wire logic         nrst_i,
  input wire logic [7:0]   reg_addr_i,
  input wire logic         reg_wr_i,
  input wire logic         reg_rd_i,
  input wire logic [7:0]   reg_wdata_i,
  input wire reg_byte_type reg_rdata_o,
  input wire logic [13:0]  phase_alarm_set_i,
  input wire logic [13:0]  phase_alarm_o,
  input wire logic         holdover_manual_o,
  input wire logic         rate_1544_o,
  input wire logic         input_eleven_prio1_o,
  input wire logic         acq_bw_forced_o,
  input wire logic         revertive_eff_o,
  input wire logic         pbo_disable_o,
  input wire logic         aux_follows_main_o,
  input wire logic         aux_digital_fb_o,
  input wire logic         out8_9_from_main_o,
  input wire ref_code_type aux_forced_ref_o,
  input wire logic         in1_cmos_o,
  input wire logic         in2_cmos_o
);
  // ====================
  // access sequences
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  sequence wr_s(logic [7:0] a);
    reg_wr_i && reg_addr_i == a;
  endsequence
  sequence rd_s(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  // ====================
  // properties
  aux_reset_a: assert property ($rose(nrst_i) |-> aux_digital_fb_o && !aux_follows_main_o)
    else $error("aux defaults wrong after reset");
  aux_outputs_a: assert property (wr_s(8'h35) |-> ##2
    aux_follows_main_o == $past(reg_wdata_i[7], 2) && out8_9_from_main_o == $past(reg_wdata_i[4], 2))
    else $error("aux outputs do not follow write");
  force_map_a: assert property (wr_s(8'h35) |-> ##2 aux_forced_ref_o ==
    (($past(reg_wdata_i[3:0], 2) inside {4'h0, 4'hf}) ? 4'h0 : $past(reg_wdata_i[3:0], 2)))
    else $error("forced reference code wrong");
  unused_bit_a: assert property (rd_s(8'h35) |=> !reg_rdata_o[5])
    else $error("unused aux bit reads one");
  main_outputs_a: assert property (wr_s(8'h34) |-> ##2
    holdover_manual_o == $past(reg_wdata_i[4], 2) && rate_1544_o == $past(reg_wdata_i[2], 2))
    else $error("main config outputs do not follow write");
  cc_format_a: assert property (wr_s(8'h36) |-> ##2
    in1_cmos_o == $past(reg_wdata_i[2], 2) && in2_cmos_o == $past(reg_wdata_i[3], 2))
    else $error("input format outputs do not follow write");
  secondary_set_a: assert property (input_eleven_prio1_o |->
    acq_bw_forced_o && pbo_disable_o && revertive_eff_o)
    else $error("secondary mode settings incomplete");
  revertive_en_read_a: assert property (rd_s(8'h34) ##0 input_eleven_prio1_o |=> reg_rdata_o[0])
    else $error("revertive_en bit not one in secondary mode");
  role_read_a: assert property (rd_s(8'h34) ##0 $stable(input_eleven_prio1_o)
    |=> reg_rdata_o[1] == !$past(input_eleven_prio1_o))
    else $error("role bit does not show pin");
  alarm_set_a: assert property (phase_alarm_set_i[0] |=> phase_alarm_o[0])
    else $error("phase alarm not set");
endmodule // tlmc_properties

bind timing_loop_master_config tlmc_properties i_tlmc_properties (.*);

// >>> sim/host_model.sv
// host side model: register port master and composite line source
`timescale 1ns/1ps
module host_model (
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       mclk_i,
  output logic [7:0]      reg_addr_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic [7:0]      reg_wdata_o,
  output logic [1:0]      cc_bit_stb_o,
  output logic [1:0]      cc_mark_o,
  output logic [1:0]      cc_bpv_o
);
  // ====================
  // idle levels
  initial begin
    {reg_addr_o, reg_wr_o, reg_rd_o, reg_wdata_o} = 18'h0;
    {cc_bit_stb_o, cc_mark_o, cc_bpv_o} = 6'h0;
  end
  // ====================
  // register cycles, released lines show inverted value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge mclk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
    repeat (2) @(negedge mclk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge mclk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask
  // ====================
  // one composite bit on input one
  task automatic send_bit(input logic m, input logic b);
    @(negedge mclk_i);
    cc_mark_o[0] = m;
    cc_bpv_o[0] = b;
    cc_bit_stb_o[0] = 1'b1;
    @(negedge mclk_i);
    cc_bit_stb_o[0] = 1'b0;
    repeat (2) @(negedge mclk_i);
  endtask
endmodule // host_model

// >>> sim/tb_timing_loop_master_config.sv
// self-checking bench of the master configuration bank
`timescale 1ns/1ps
module tb_timing_loop_master_config;
  logic        mclk_i = 1'b0;
  logic        nrst_i, primary_pin_i, rate_strap_pin_i, frame_sync_pin_i, local_osc_in_i;
  logic        reg_wr_i, reg_rd_i, main_locked_i;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [3:0]  main_lock_src_i, fsync_source_i, aux_forced_ref_o;
  logic [13:0] phase_alarm_set_i, phase_alarm_clr_i, ref_valid_i, phase_alarm_o;
  logic [1:0]  cc_bit_stb_i, cc_mark_i, cc_bpv_i, cc_timing_pulse_o, cc_bucket_inc_o, cc_invalid_o;
  logic        fsync_used_o, fsync_pulse_o, local_osc_edge_o, holdover_manual_o, rate_1544_o;
  logic        input_eleven_prio1_o, acq_bw_forced_o, revertive_eff_o, pbo_disable_o;
  logic        aux_follows_main_o, aux_digital_fb_o, out8_9_from_main_o, aux_switch_inhibit_o;
  logic        in1_cmos_o, in2_cmos_o;
  int          n_fail = 0;
  int          n_tests = 0;
  int          n_bump = 0;
  int          b0;
  // ====================
  // design and host
  always #20 mclk_i = ~mclk_i;
  timing_loop_master_config #(.ALARM_TIMEOUT_CYC(32'd50), .BUCKET_INT_CYC(32'd40))
    i_timing_loop_master_config (.*);
  host_model i_host_model (.reg_rdata_i(reg_rdata_o), .mclk_i(mclk_i), .reg_addr_o(reg_addr_i),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i),
    .cc_bit_stb_o(cc_bit_stb_i), .cc_mark_o(cc_mark_i), .cc_bpv_o(cc_bpv_i));
  always @(posedge mclk_i) if (cc_bucket_inc_o[0] === 1'b1) n_bump++;
  // ====================
  // checking helpers
  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host_model.rd(a, d);
    chk(d, exp);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    wait_n(5000);
    n_fail++;
    finish_test;
  end
  // ====================
  // tests
  initial begin
    nrst_i = 1'b0;
    primary_pin_i = 1'b1;
    rate_strap_pin_i = 1'b1;
    frame_sync_pin_i = 1'b0;
    local_osc_in_i = 1'b0;
    main_locked_i = 1'b0;
    main_lock_src_i = 4'h5;
    fsync_source_i = 4'h5;
    phase_alarm_set_i = 14'h0;
    phase_alarm_clr_i = 14'h0;
    ref_valid_i = 14'h3fff;
    wait_n(4);
    nrst_i = 1'b1;
    wait_n(6);
    rdc(8'h34, 8'hc6);
    rdc(8'h35, 8'h40);
    rdc(8'h36, 8'h02);
    rdc(8'h40, 8'h00);
    i_host_model.wr(8'h35, 8'hff);
    rdc(8'h35, 8'hdf);
    for (int c = 0; c < 16; c++) begin
      i_host_model.wr(8'h35, 8'(c));
      chk({aux_follows_main_o, out8_9_from_main_o, aux_forced_ref_o}, (c == 0 || c == 15) ? 6'h0 : 6'(c));
    end
    i_host_model.wr(8'h35, 8'hd3);
    chk({aux_follows_main_o, aux_digital_fb_o, out8_9_from_main_o}, 3'b111);
    ref_valid_i[2] = 1'b0;
    wait_n(3);
    chk(aux_switch_inhibit_o, 1'b1);
    ref_valid_i[2] = 1'b1;
    wait_n(3);
    chk(aux_switch_inhibit_o, 1'b0);
    i_host_model.wr(8'h34, 8'h15);
    rdc(8'h34, 8'h17);
    chk({holdover_manual_o, rate_1544_o, revertive_eff_o, input_eleven_prio1_o}, 4'he);
    i_host_model.wr(8'h34, 8'h08);
    chk(fsync_used_o, 1'b1);
    i_host_model.wr(8'h34, 8'h88);
    chk(fsync_used_o, 1'b0);
    main_locked_i = 1'b1;
    wait_n(3);
    chk(fsync_used_o, 1'b1);
    main_lock_src_i = 4'h6;
    wait_n(3);
    chk(fsync_used_o, 1'b0);
    i_host_model.wr(8'h34, 8'h00);
    local_osc_in_i = 1'b1;
    wait_n(3);
    chk(local_osc_edge_o, 1'b1);
    primary_pin_i = 1'b0;
    wait_n(6);
    rdc(8'h34, 8'h01);
    chk({input_eleven_prio1_o, acq_bw_forced_o, pbo_disable_o, revertive_eff_o}, 4'hf);
    primary_pin_i = 1'b1;
    wait_n(6);
    rdc(8'h34, 8'h02);
    chk({input_eleven_prio1_o, acq_bw_forced_o, revertive_eff_o}, 3'b000);
    i_host_model.wr(8'h34, 8'h40);
    phase_alarm_set_i[0] = 1'b1;
    wait_n(1);
    phase_alarm_set_i[0] = 1'b0;
    chk(phase_alarm_o[0], 1'b1);
    wait_n(45);
    chk(phase_alarm_o[0], 1'b1);
    wait_n(10);
    chk(phase_alarm_o[0], 1'b0);
    i_host_model.wr(8'h34, 8'h00);
    phase_alarm_set_i[1] = 1'b1;
    wait_n(1);
    phase_alarm_set_i[1] = 1'b0;
    wait_n(60);
    chk(phase_alarm_o[1], 1'b1);
    phase_alarm_clr_i[1] = 1'b1;
    wait_n(1);
    phase_alarm_clr_i[1] = 1'b0;
    wait_n(1);
    chk(phase_alarm_o[1], 1'b0);
    b0 = n_bump;
    i_host_model.wr(8'h36, 8'h20);
    repeat (24) i_host_model.send_bit(1'b1, 1'b0);
    wait_n(4);
    chk({cc_invalid_o[0], 8'(n_bump - b0)}, 9'h100);
    for (int i = 0; i < 16; i++) i_host_model.send_bit(1'b1, i % 8 == 7);
    wait_n(4);
    chk(cc_invalid_o[0], 1'b0);
    i_host_model.wr(8'h36, 8'h10);
    repeat (2) i_host_model.send_bit(1'b0, 1'b0);
    wait_n(4);
    chk(cc_invalid_o[0], 1'b1);
    i_host_model.wr(8'h36, 8'h14);
    wait_n(2);
    chk({in1_cmos_o, in2_cmos_o, cc_invalid_o[0]}, 3'b100);
    i_host_model.wr(8'h36, 8'h40);
    b0 = n_bump;
    repeat (24) i_host_model.send_bit(1'b1, 1'b0);
    wait_n(45);
    chk((n_bump - b0) >= 2 && (n_bump - b0) <= 4, 1'b1);
    finish_test;
  end
endmodule // tb_timing_loop_master_config
